// [verilog/mgrr_defines.svh]
`ifndef MGRR_DEFINES_SVH
`define MGRR_DEFINES_SVH

// sensor register addresses
`define MGRR_ADDR_ID        8'h01
`define MGRR_ADDR_WRAP_LOW  8'h03
`define MGRR_ADDR_ST_FIRST  8'h10
`define MGRR_ADDR_X_LOW     8'h11
`define MGRR_ADDR_X_HIGH    8'h12
`define MGRR_ADDR_Y_LOW     8'h13
`define MGRR_ADDR_Y_HIGH    8'h14
`define MGRR_ADDR_Z_LOW     8'h15
`define MGRR_ADDR_Z_HIGH    8'h16
`define MGRR_ADDR_ST_END    8'h18
`define MGRR_ADDR_CTRL_BASE 8'h30
`define MGRR_ADDR_MODE      8'h31
`define MGRR_ADDR_RESET     8'h32
`define MGRR_ADDR_TEST_A    8'h33
`define MGRR_ADDR_TEST_B    8'h34
`define MGRR_ADDR_ZERO      8'h00

// mode field encodings
`define MGRR_MODE_OFF       5'h00
`define MGRR_MODE_SINGLE    5'h01
`define MGRR_MODE_CONT1     5'h02
`define MGRR_MODE_CONT2     5'h04
`define MGRR_MODE_CONT3     5'h06
`define MGRR_MODE_CONT4     5'h08
`define MGRR_MODE_SELFTEST  5'h10

// bit positions
`define MGRR_BIT_READY      0
`define MGRR_BIT_SKIPPED    1
`define MGRR_BIT_OVF        3
`define MGRR_BIT_SOFT_RESET_BIT       0

// axis output limits
`define MGRR_FIELD_MAX      16'h7FF0
`define MGRR_FIELD_MIN      16'h8010

// reader's own registers on the bus
`define MGRR_AXI_CMD        4'h0
`define MGRR_AXI_STAT       4'h4
`define MGRR_CMD_WE         16
`define MGRR_CMD_CONT       17
`define MGRR_STAT_BUSY      0
`define MGRR_STAT_ERR       1
`define MGRR_STAT_SESSION   2
`define MGRR_RESP_OKAY      2'h0
`define MGRR_RESP_SLVERR    2'h2

`endif

// [verilog/mgrr_pkg.sv]
`default_nettype none

package mgrr_pkg;

	typedef enum logic {
		MGRR_IDLE,
		MGRR_WAIT
	} mgrr_phase_t;

	typedef struct packed {
		logic [4:0]       mode;
		logic             ready;
		logic             skipped;
		logic             ovf;
		logic             session;
		logic [2:0][15:0] field;
		logic [7:0]       ptr;
		logic             ack;
		logic [7:0]       rdata;
	} mgrr_dev_state_t;

	typedef struct packed {
		mgrr_phase_t phase;
		logic        awready;
		logic        wready;
		logic        aw_have;
		logic        w_have;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] axi_rdata;
		logic [31:0] cmd;
		logic        err;
		logic        session;
		logic [7:0]  ptr;
		logic        ptr_ok;
		logic        req;
		logic        start;
		logic        we;
		logic [7:0]  addr;
		logic [7:0]  link_wdata;
		logic [7:0]  rdata;
	} mgrr_host_state_t;

	// one of the seven defined mode codes
	function automatic logic mgrr_mode_valid(input logic [4:0] m);
		return (m == 5'h00) || (m == 5'h01) || (m == 5'h02) || (m == 5'h04) ||
			(m == 5'h06) || (m == 5'h08) || (m == 5'h10);
	endfunction

	// one of the four continuous modes
	function automatic logic mgrr_mode_cont(input logic [4:0] m);
		return (m == 5'h02) || (m == 5'h04) || (m == 5'h06) || (m == 5'h08);
	endfunction

endpackage

`default_nettype wire

// [verilog/mgrr_link_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface mgrr_link_if;
	logic       req;
	logic       start;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;

	modport reader (
		output req,
		output start,
		output we,
		output addr,
		output wdata,
		input  ack,
		input  rdata
	);

	modport sensor (
		input  req,
		input  start,
		input  we,
		input  addr,
		input  wdata,
		output ack,
		output rdata
	);
endinterface

`default_nettype wire

// [verilog/mgrr_addr_step.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mgrr_defines.svh"

module mgrr_addr_step (
	// current address
	input  wire logic [7:0] i_addr,
	// following address and window membership
	output logic      [7:0] o_next,
	output logic            o_in_window
);
	always_comb begin
		if (i_addr == `MGRR_ADDR_WRAP_LOW) begin
			o_next = `MGRR_ADDR_ST_FIRST;
		end else if (i_addr == `MGRR_ADDR_ST_END) begin
			o_next = `MGRR_ADDR_ZERO;
		end else if (i_addr == `MGRR_ADDR_RESET) begin
			o_next = `MGRR_ADDR_CTRL_BASE;
		end else begin
			o_next = i_addr + 8'h01;
		end
	end

	// gap 04h..0Fh is not part of the burst sequence
	assign o_in_window = (i_addr <= `MGRR_ADDR_WRAP_LOW) ||
		((i_addr >= `MGRR_ADDR_ST_FIRST) && (i_addr <= `MGRR_ADDR_ST_END)) ||
		((i_addr >= `MGRR_ADDR_CTRL_BASE) && (i_addr <= `MGRR_ADDR_RESET));
endmodule

`default_nettype wire

// [verilog/mgrr_sensor.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mgrr_defines.svh"

module mgrr_sensor
	import mgrr_pkg::*;
#(
	// arbitrary neutral identity value
	parameter logic [7:0] ID_CODE = 8'h5A
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rstn,
	// register link to the reader
	mgrr_link_if.sensor           link,
	// measurement source
	input  wire logic             i_sample_valid,
	input  wire logic [2:0][15:0] i_sample_axes,
	input  wire logic             i_sample_ovf,
	// observed operation
	output logic      [4:0]       o_mode,
	output logic                  o_ready
);

	mgrr_dev_state_t  s;
	mgrr_dev_state_t  next_s;
	logic [2:0][15:0] clamped;
	logic [7:0]       eff_addr;
	logic [7:0]       step_next;
	logic             req_new;
	logic             cont;
	logic             measuring;

	// a request is served once; ack drops the cycle after
	assign req_new   = link.req && !s.ack;
	assign eff_addr  = link.start ? link.addr : s.ptr;
	assign cont      = mgrr_mode_cont(s.mode);
	assign measuring = cont || (s.mode == `MGRR_MODE_SINGLE) ||
		(s.mode == `MGRR_MODE_SELFTEST);

	// next burst address from the shared sequencer
	mgrr_addr_step u_step (
		.i_addr      (eff_addr),
		.o_next      (step_next),
		.o_in_window ()
	);

	// per-axis saturation of raw samples
	genvar a;
	generate
		for (a = 0; a < 3; a++) begin : g_clamp
			always_comb begin
				if ($signed(i_sample_axes[a]) > $signed(`MGRR_FIELD_MAX)) begin
					clamped[a] = `MGRR_FIELD_MAX;
				end else if ($signed(i_sample_axes[a]) < $signed(`MGRR_FIELD_MIN)) begin
					clamped[a] = `MGRR_FIELD_MIN;
				end else begin
					clamped[a] = i_sample_axes[a];
				end
			end
		end
	endgenerate

	// next state: link access first, sample arrival after it
	always_comb begin
		logic clr;
		logic soft_reset_bit;
		clr    = 1'b0;
		soft_reset_bit   = 1'b0;
		next_s = s;
		next_s.ack = 1'b0;
		if (req_new) begin
			next_s.ack   = 1'b1;
			next_s.rdata = 8'h00;
			next_s.ptr   = step_next;
			if (!link.we) begin
				unique case (eff_addr)
					`MGRR_ADDR_ID: begin
						next_s.rdata = ID_CODE;
					end
					`MGRR_ADDR_ST_FIRST: begin
						next_s.rdata[`MGRR_BIT_READY]   = s.ready;
						next_s.rdata[`MGRR_BIT_SKIPPED] = s.skipped;
					end
					`MGRR_ADDR_X_LOW: next_s.rdata = s.field[0][7:0];
					`MGRR_ADDR_X_HIGH: next_s.rdata = s.field[0][15:8];
					`MGRR_ADDR_Y_LOW: next_s.rdata = s.field[1][7:0];
					`MGRR_ADDR_Y_HIGH: next_s.rdata = s.field[1][15:8];
					`MGRR_ADDR_Z_LOW: next_s.rdata = s.field[2][7:0];
					`MGRR_ADDR_Z_HIGH: next_s.rdata = s.field[2][15:8];
					`MGRR_ADDR_ST_END: begin
						next_s.rdata[`MGRR_BIT_OVF] = s.ovf;
					end
					`MGRR_ADDR_MODE: begin
						next_s.rdata[4:0] = s.mode;
					end
					default: begin
						next_s.rdata = 8'h00;
					end
				endcase
				if ((eff_addr >= `MGRR_ADDR_X_LOW) && (eff_addr <= `MGRR_ADDR_Z_HIGH)) begin
					clr = 1'b1;
					if (cont) begin
						next_s.session = 1'b1;
					end
				end
				if (eff_addr == `MGRR_ADDR_ST_END) begin
					clr = 1'b1;
					next_s.session = 1'b0;
				end
			end else begin
				if ((eff_addr == `MGRR_ADDR_MODE) && mgrr_mode_valid(link.wdata[4:0])) begin
					next_s.mode = link.wdata[4:0];
				end
				if ((eff_addr == `MGRR_ADDR_RESET) && link.wdata[`MGRR_BIT_SOFT_RESET_BIT]) begin
					soft_reset_bit = 1'b1;
				end
			end
		end

		if (clr) begin
			next_s.ready   = 1'b0;
			next_s.skipped = 1'b0;
		end

		// a sample landing with a clearing read still raises its flag
		if (i_sample_valid && measuring) begin
			if (s.session && cont) begin
				next_s.skipped = 1'b1;
			end else begin
				next_s.field = clamped;
				next_s.ovf   = i_sample_ovf;
				next_s.ready = 1'b1;
				if (cont && s.ready && !clr) begin
					next_s.skipped = 1'b1;
				end
				// one-shot modes fall back to power-down
				if (!cont) begin
					next_s.mode = `MGRR_MODE_OFF;
				end
			end
		end

		// every register back to zero, bit reads zero
		if (soft_reset_bit) begin
			next_s     = '0;
			next_s.ack = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign link.ack   = s.ack;
	assign link.rdata = s.rdata;
	assign o_mode     = s.mode;
	assign o_ready    = s.ready;

endmodule

`default_nettype wire

// [verilog/mgrr_reader.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mgrr_defines.svh"

module mgrr_reader
	import mgrr_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	// axi4-lite write address and data
	input  wire logic [3:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	// axi4-lite write response
	output logic             o_bvalid,
	output logic [1:0]       o_bresp,
	input  wire logic        i_bready,
	// axi4-lite read
	input  wire logic [3:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic             o_rvalid,
	output logic [1:0]       o_rresp,
	output logic [31:0]      o_rdata,
	input  wire logic        i_rready,
	// register link to the sensor
	mgrr_link_if.reader      link
);

	mgrr_host_state_t s;
	mgrr_host_state_t next_s;
	logic [7:0]       step_next;
	logic             last_in_win;

	// mirror of the sensor's burst pointer
	mgrr_addr_step u_step (
		.i_addr      (s.addr),
		.o_next      (step_next),
		.o_in_window (last_in_win)
	);

	// bus slave and link sequencing in one pass
	always_comb begin
		logic       launch;
		logic       cont;
		logic       bad;
		logic [7:0] eff;
		logic [7:0] wbyte;
		launch = 1'b0;
		cont   = 1'b0;
		bad    = 1'b0;
		eff    = 8'h00;
		wbyte  = 8'h00;
		next_s = s;
		if (s.bvalid && i_bready) begin
			next_s.bvalid = 1'b0;
		end
		// write completes once both halves are in
		if (s.aw_have && s.w_have && !s.bvalid) begin
			next_s.bvalid  = 1'b1;
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			if (s.awaddr == `MGRR_AXI_CMD) begin
				for (int b = 0; b < 4; b++) begin
					if (s.wstrb[b]) begin
						next_s.cmd[b*8 +: 8] = s.wdata[b*8 +: 8];
					end
				end
				next_s.bresp = `MGRR_RESP_OKAY;
				launch = 1'b1;
			end else begin
				next_s.bresp = `MGRR_RESP_SLVERR;
			end
		end
		if (i_awvalid && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr  = i_awaddr;
		end
		if (i_wvalid && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata  = i_wdata;
			next_s.wstrb  = i_wstrb;
		end
		next_s.awready = !next_s.aw_have && !next_s.bvalid;
		next_s.wready  = !next_s.w_have && !next_s.bvalid;

		// read channel, no side effects
		if (s.rvalid && i_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (i_arvalid && s.arready) begin
			next_s.rvalid    = 1'b1;
			next_s.rresp     = `MGRR_RESP_OKAY;
			next_s.axi_rdata = 32'h0000_0000;
			if (i_araddr == `MGRR_AXI_CMD) begin
				next_s.axi_rdata = s.cmd;
			end else if (i_araddr == `MGRR_AXI_STAT) begin
				next_s.axi_rdata[`MGRR_STAT_BUSY]    = (s.phase == MGRR_WAIT);
				next_s.axi_rdata[`MGRR_STAT_ERR]     = s.err;
				next_s.axi_rdata[`MGRR_STAT_SESSION] = s.session;
				next_s.axi_rdata[15:8]               = s.rdata;
			end else begin
				next_s.rresp = `MGRR_RESP_SLVERR;
			end
		end
		next_s.arready = !next_s.rvalid;

		// command checks before anything reaches the link
		cont  = next_s.cmd[`MGRR_CMD_CONT];
		eff   = cont ? s.ptr : next_s.cmd[7:0];
		wbyte = next_s.cmd[15:8];
		bad   = (s.phase == MGRR_WAIT);
		bad   = bad || (cont && !(s.ptr_ok && last_in_win));
		bad   = bad || (eff == `MGRR_ADDR_TEST_A) || (eff == `MGRR_ADDR_TEST_B);
		bad   = bad || (next_s.cmd[`MGRR_CMD_WE] && (eff == `MGRR_ADDR_MODE) &&
			!mgrr_mode_valid(wbyte[4:0]));
		bad   = bad || (next_s.cmd[`MGRR_CMD_WE] && s.session);

		unique case (s.phase)
			MGRR_IDLE: begin
				if (launch && !bad) begin
					next_s.err        = 1'b0;
					next_s.req        = 1'b1;
					next_s.start      = !cont;
					next_s.we         = next_s.cmd[`MGRR_CMD_WE];
					next_s.addr       = eff;
					next_s.link_wdata = wbyte;
					next_s.phase      = MGRR_WAIT;
					if (!next_s.we && (eff >= `MGRR_ADDR_X_LOW) &&
						(eff <= `MGRR_ADDR_Z_HIGH)) begin
						next_s.session = 1'b1;
					end
					if (!next_s.we && (eff == `MGRR_ADDR_ST_END)) begin
						next_s.session = 1'b0;
					end
				end else if (launch) begin
					next_s.err = 1'b1;
				end
			end
			MGRR_WAIT: begin
				if (launch) begin
					next_s.err = 1'b1;
				end
				if (link.ack) begin
					next_s.req    = 1'b0;
					next_s.rdata  = link.rdata;
					next_s.phase  = MGRR_IDLE;
					next_s.ptr    = step_next;
					next_s.ptr_ok = 1'b1;
					// soft reset sends the sensor pointer home
					if (s.we && (s.addr == `MGRR_ADDR_RESET) &&
						s.link_wdata[`MGRR_BIT_SOFT_RESET_BIT]) begin
						next_s.ptr     = `MGRR_ADDR_ZERO;
						next_s.ptr_ok  = 1'b0;
						next_s.session = 1'b0;
					end
				end
			end
		endcase
	end

	// single state register
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign o_awready  = s.awready;
	assign o_wready   = s.wready;
	assign o_bvalid   = s.bvalid;
	assign o_bresp    = s.bresp;
	assign o_arready  = s.arready;
	assign o_rvalid   = s.rvalid;
	assign o_rresp    = s.rresp;
	assign o_rdata    = s.axi_rdata;
	assign link.req   = s.req;
	assign link.start = s.start;
	assign link.we    = s.we;
	assign link.addr  = s.addr;
	assign link.wdata = s.link_wdata;

endmodule

`default_nettype wire

// [dv/mgrr_props.sv]
`timescale 1ns/1ns
`default_nettype none

module mgrr_props #(
	parameter logic [7:0] ID_CODE = 8'h5A
) (
	// clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rstn,
	// link from reader
	input wire logic       req,
	input wire logic       start,
	input wire logic       we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	// link from sensor
	input wire logic       ack,
	input wire logic [7:0] rdata
);
	// first cycle of an addressed read, when the sensor decodes it
	logic rd_go;
	assign rd_go = req && !ack && start && !we;

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	ack_one_pulse_a:
		assert property (ack |=> !ack) else $error("ack longer than one cycle");
	ack_after_req_a:
		assert property ($rose(req) |=> ack) else $error("ack late");
	req_holds_a:
		assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	req_drops_a:
		assert property (ack |=> !req) else $error("request kept after ack");
	ack_needs_req_a:
		assert property (ack |-> $past(req)) else $error("ack without request");
	id_fixed_a:
		assert property (rd_go && addr == 8'h01 |=> rdata == ID_CODE) else $error("bad id byte");
	unlisted_zero_a:
		assert property (rd_go && addr inside {8'h00, 8'h02, 8'h03, 8'h20, 8'h30}
			|=> rdata == 8'h00)
		else $error("unlisted address not zero");
	stat_bits_zero_a:
		assert property (rd_go && addr == 8'h10 |=> rdata[7:2] == 6'h00)
		else $error("status first spare bits set");
	end_bits_zero_a:
		assert property (rd_go && addr == 8'h18 |=> {rdata[7], rdata[2:0]} == 4'h0)
		else $error("status end spare bits set");
	mode_bits_zero_a:
		assert property (rd_go && addr == 8'h31 |=> rdata[7:5] == 3'h0)
		else $error("mode spare bits set");
	soft_reset_bit_clears_a:
		assert property (req && !ack && we && addr == 8'h32 && wdata[0] |=> rdata == 8'h00)
		else $error("soft reset answer not zero");

	// main traffic kinds
	cover property (rd_go && addr == 8'h01);
	cover property ($rose(req) && we && addr == 8'h31);
	cover property (req && !start);
endmodule

`default_nettype wire

// [dv/mgrr_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module mgrr_tb;
	// arbitrary identity value
	localparam logic [7:0] ID = 8'h5A;
	logic             clk, rstn;
	logic [3:0]       awaddr, araddr, wstrb;
	logic             awvalid, wvalid, bready, arvalid, rready;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [31:0]      wdata, rdata;
	logic [1:0]       bresp, rresp, rs;
	logic             s_valid, s_ovf, ready;
	logic [2:0][15:0] axes;
	logic [4:0]       mode;
	logic [31:0]      d;
	logic [7:0]       codes [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h10};
	// bytes met on a burst starting at 0x02
	logic [7:0]       sq [13] = '{8'h00, 8'h00, 8'h01, 8'h34, 8'h12, 8'h10, 8'h80,
		8'hF0, 8'h7F, 8'h00, 8'h08, 8'h00, ID};
	int               err_total, checks, i;

	always #4 clk = ~clk;

	mgrr_link_if mgrr_link_if_inst ();
	mgrr_sensor #(.ID_CODE(ID)) mgrr_sensor_inst (.i_ref_clk(clk), .i_rstn(rstn),
		.link(mgrr_link_if_inst), .i_sample_valid(s_valid), .i_sample_axes(axes),
		.i_sample_ovf(s_ovf), .o_mode(mode), .o_ready(ready));
	mgrr_reader mgrr_reader_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rvalid(rvalid), .o_rresp(rresp), .o_rdata(rdata), .i_rready(rready),
		.link(mgrr_link_if_inst));
	mgrr_props #(.ID_CODE(ID)) mgrr_props_inst (.i_ref_clk(clk), .i_rstn(rstn),
		.req(mgrr_link_if_inst.req), .start(mgrr_link_if_inst.start),
		.we(mgrr_link_if_inst.we), .addr(mgrr_link_if_inst.addr),
		.wdata(mgrr_link_if_inst.wdata), .ack(mgrr_link_if_inst.ack),
		.rdata(mgrr_link_if_inst.rdata));

	// single place where the run ends
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	// bus write: each channel released at the edge that takes it
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			err_total++;
			end_sim;
		end
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			err_total++;
			end_sim;
		end
	endtask

	// one command through the command register, then poll busy
	task automatic ck(input string nm, input logic [7:0] a, input logic c, input logic w,
		input logic [7:0] wb, input logic ee, input logic [7:0] eb);
		logic [31:0] s;
		logic [1:0]  r;
		int          n;
		axw(4'h0, {14'h0, c, w, wb, a}, r);
		// command register always answers okay
		chk({nm, " bresp"}, 2'h0, r);
		for (n = 0; n < 20; n++) begin
			axr(4'h4, s, r);
			if (!s[0]) break;
		end
		if (n == 20) begin
			err_total++;
			end_sim;
		end
		chk({nm, " rresp"}, 2'h0, r);
		chk({nm, " err"}, ee, s[1]);
		if (!w) chk(nm, eb, s[15:8]);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] eb);
		ck(nm, a, 1'b0, 1'b0, 8'h00, 1'b0, eb);
	endtask

	task automatic wr(input string nm, input logic [7:0] a, input logic [7:0] wb, input logic ee);
		ck(nm, a, 1'b0, 1'b1, wb, ee, 8'h00);
	endtask

	// one-cycle sample pulse
	task automatic smp(input logic [2:0][15:0] v, input logic o);
		@(posedge clk);
		s_valid <= 1'b1;
		axes <= v;
		s_ovf <= o;
		@(posedge clk);
		s_valid <= 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, s_valid, s_ovf} = '0;
		{awaddr, araddr, wdata, axes} = '0;
		wstrb = 4'hF;
		err_total = 0;
		checks = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd("id", 8'h01, ID);
		rd("status first", 8'h10, 8'h00);
		rd("status end", 8'h18, 8'h00);
		rd("mode", 8'h31, 8'h00);
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			wr("mode set", 8'h31, codes[i], 1'b0);
			rd("mode back", 8'h31, codes[i]);
			chk("o_mode", codes[i], mode);
		end
		wr("bad mode", 8'h31, 8'h03, 1'b1);
		$display("test modes done");
		wr("single", 8'h31, 8'h01, 1'b0);
		smp({16'h7FFF, 16'h8000, 16'h1234}, 1'b1);
		for (i = 0; i < 13; i++) begin
			// this burst passes status end before ID, closing the read
			ck("burst", 8'h02, i != 0, 1'b0, 8'h00, 1'b0, sq[i]);
			if (i == 0) chk("o_ready", 1, ready);
		end
		chk("single done", 0, mode);
		rd("flags clear", 8'h10, 8'h00);
		$display("test single done");
		wr("continuous", 8'h31, 8'h02, 1'b0);
		smp({16'h0, 16'h0, 16'h0101}, 1'b0);
		smp({16'h0, 16'h0, 16'h0202}, 1'b1);
		rd("overrun", 8'h10, 8'h03);
		rd("newest low", 8'h11, 8'h02);
		smp({16'h0, 16'h0, 16'h0303}, 1'b0);
		rd("in session", 8'h10, 8'h02);
		rd("kept low", 8'h11, 8'h02);
		wr("write in session", 8'h31, 8'h00, 1'b1);
		rd("overflow", 8'h18, 8'h08);
		rd("closed", 8'h10, 8'h00);
		$display("test continuous done");
		rd("ctl mode", 8'h31, 8'h02);
		ck("ctl reset", 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
		ck("ctl base", 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
		ck("ctl wrap", 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h02);
		$display("test control window done");
		// refused, so the byte of the wrap read stays in status
		ck("test reg", 8'h33, 1'b0, 1'b0, 8'h00, 1'b1, 8'h02);
		rd("unlisted", 8'h20, 8'h00);
		ck("outside burst", 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 8'h00);
		axw(4'h8, 32'h0, rs);
		chk("unmapped write resp", 2'h2, rs);
		axr(4'hC, d, rs);
		chk("unmapped read resp", 2'h2, rs);
		chk("unmapped read data", 0, d);
		$display("test refusals done");
		wr("soft reset", 8'h32, 8'h01, 1'b0);
		chk("o_mode after reset", 0, mode);
		rd("reset bit", 8'h32, 8'h00);
		rd("mode after reset", 8'h31, 8'h00);
		$display("test soft reset done");
		end_sim;
	end
endmodule

`default_nettype wire
